// file: hw/nfcr_pkg.sv
// package of register map, field layout, reset values and timing for the configuration page
package nfcr_pkg;
  localparam logic [7:0] OFF_SPEED    = 8'h1f;
  localparam logic [7:0] OFF_PAGE     = 8'h20;
  localparam logic [7:0] OFF_CRC_HI   = 8'h21;
  localparam logic [7:0] OFF_CRC_LO   = 8'h22;
  localparam logic [7:0] OFF_GSNOFF   = 8'h23;
  localparam logic [7:0] OFF_PULSE_WIDTH_VALUE = 8'h24;
  localparam logic [7:0] OFF_TXPHASE  = 8'h25;
  // chosen offsets for the driver-on conductance register and loose control and status bits
  localparam logic [7:0] OFF_GSNON    = 8'h27;
  localparam logic [7:0] OFF_CTRL     = 8'h40;
  localparam logic [7:0] OFF_STATUS   = 8'h44;

  localparam logic [7:0] RST_SPEED    = 8'heb;
  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_CRC      = 8'hff;
  localparam logic [7:0] RST_GSN      = 8'h88;
  localparam logic [7:0] RST_PULSE_WIDTH_VALUE = 8'h26;
  localparam logic [7:0] RST_TXPHASE  = 8'h87;
  localparam logic [7:0] RST_CTRL     = 8'h00;

  localparam int PAGE_EN_BIT   = 7;
  localparam logic [7:0] PAGE_MASK = 8'h83;
  localparam int CTRL_PWRDN    = 0;
  localparam int CTRL_HIGH_BIT_FIRST_ORDER = 1;
  localparam int CTRL_DRVON    = 2;
  localparam int CTRL_LOADMOD  = 3;
  localparam logic [7:0] CTRL_MASK = 8'h0f;
  localparam int RXCLK_BIT     = 7;
  localparam logic [3:0] GS_TOP = 4'h8;
  localparam logic [4:0] SUB_PERIOD = 5'h10;
  localparam logic [7:0] MOD_MOD8_MASK = 8'h07;

  typedef struct packed {
    logic [3:0] idle;
    logic [3:0] mod;
  } nfcr_gsn_t;

  typedef struct packed {
    logic [2:0] coarse;
    logic [3:0] fine;
  } nfcr_speed_t;
endpackage : nfcr_pkg

// file: hw/nfcr_config_regs.sv
// configuration page registers of the contactless frontend with apb slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module nfcr_config_regs #(
  parameter int ADDR_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [5:0]        hostAddrLatch,
  input  wire logic [3:0]        hostAddrPins,
  input  wire logic              hostUsesPins,
  output logic [5:0]             effRegAddr,
  input  wire logic [15:0]       checksumValue,
  input  wire logic              checksumReady,
  output nfcr_pkg::nfcr_speed_t  uartSpeed,
  output nfcr_pkg::nfcr_gsn_t    nConductance,
  input  wire logic              isInitiator,
  input  wire logic              isPassiveTarget106,
  output logic [8:0]             millerPulseClocks,
  output logic [4:0]             subLowClocks,
  output logic [4:0]             subHighClocks,
  output logic [6:0]             transmitPhaseOffset,
  output logic                   receiveClockSource
);
  import nfcr_pkg::*;

  // the register index sits in byte address bits 9..2
  if (ADDR_W < 10)
  begin : g_addr_w_check
    $error("nfcr_config_regs: ADDR_W must be at least 10");
  end

  logic [7:0] speed_r;
  logic [7:0] page_r;
  logic [7:0] gsnOff_r;
  logic [7:0] gsnOn_r;
  logic [7:0] pulse_width_value_r;
  logic [7:0] txPhase_r;
  logic [7:0] ctrl_r;
  logic [7:0] rdData_nxt;
  logic       mapped_nxt;
  logic [7:0] crcHi;
  logic [7:0] crcLo;
  logic [7:0] regOff;
  logic       wrStb;
  logic       wrEn;
  logic [7:0] wrByte;
  logic       pwrDown;
  logic       high_bit_first_order;
  nfcr_gsn_t  gsSel;

  // zero-wait slave; register index is the word address, byte address is four times it
  assign pready  = 1'b1;
  assign regOff  = paddr[9:2];
  assign wrStb   = psel && penable && pwrite && pstrb[0];
  assign wrEn    = wrStb && (paddr[1:0] == 2'b00); // unaligned writes dropped
  assign wrByte  = pwdata[7:0];
  assign pwrDown = ctrl_r[CTRL_PWRDN];
  assign high_bit_first_order = ctrl_r[CTRL_HIGH_BIT_FIRST_ORDER];

  // writable registers, reserved page bits masked
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      speed_r    <= RST_SPEED;
      page_r     <= RST_PAGE;
      gsnOff_r   <= RST_GSN;
      gsnOn_r    <= RST_GSN;
      pulse_width_value_r <= RST_PULSE_WIDTH_VALUE;
      txPhase_r  <= RST_TXPHASE;
      ctrl_r     <= RST_CTRL;
    end
    else if (wrEn)
    begin
      unique case (regOff)
        OFF_SPEED:    speed_r    <= wrByte & 8'hef;
        OFF_PAGE:     page_r     <= wrByte & PAGE_MASK;
        OFF_GSNOFF:   gsnOff_r   <= wrByte;
        OFF_GSNON:    gsnOn_r    <= wrByte;
        OFF_PULSE_WIDTH_VALUE: pulse_width_value_r <= wrByte;
        OFF_TXPHASE:  txPhase_r  <= wrByte;
        OFF_CTRL:     ctrl_r     <= wrByte & CTRL_MASK;
        default:      ;
      endcase
    end
  end

  // checksum bytes, bit order reversed per byte in high-bit-first mode
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      crcHi[i] = high_bit_first_order ? checksumValue[15-i] : checksumValue[8+i];
      crcLo[i] = high_bit_first_order ? checksumValue[7-i]  : checksumValue[i];
    end
  end

  // read decode; unmapped offsets answer with slave error
  always_comb
  begin
    rdData_nxt = 8'h00;
    mapped_nxt = 1'b1;
    unique case (regOff)
      OFF_SPEED:    rdData_nxt = speed_r;
      OFF_PAGE:     rdData_nxt = page_r;
      OFF_CRC_HI:   rdData_nxt = reset ? RST_CRC : crcHi;
      OFF_CRC_LO:   rdData_nxt = reset ? RST_CRC : crcLo;
      OFF_GSNOFF:   rdData_nxt = gsnOff_r;
      OFF_GSNON:    rdData_nxt = gsnOn_r;
      OFF_PULSE_WIDTH_VALUE: rdData_nxt = pulse_width_value_r;
      OFF_TXPHASE:  rdData_nxt = txPhase_r;
      OFF_CTRL:     rdData_nxt = ctrl_r;
      OFF_STATUS:   rdData_nxt = {7'h00, checksumReady};
      default:      mapped_nxt = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
      mapped_nxt = 1'b0;
  end

  // error valid in the access phase
  assign pslverr = psel && penable && !mapped_nxt;

  // read data captured at the end of setup so it stands through the access phase
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= pwrite ? 32'h00000000 : {24'h000000, rdData_nxt};
    else if (!psel)
      prdata <= 32'h00000000;
  end

  // effective register address from page or latch
  always_comb
  begin
    if (page_r[PAGE_EN_BIT])
      effRegAddr = {page_r[1:0], hostUsesPins ? hostAddrPins : hostAddrLatch[3:0]};
    else
      effRegAddr = hostAddrLatch;
  end

  // driver n conductance select and power-down forcing
  always_comb
  begin
    gsSel = (ctrl_r[CTRL_DRVON] && !ctrl_r[CTRL_LOADMOD]) ? gsnOn_r : gsnOff_r;
    nConductance.idle = pwrDown ? (gsSel.idle | GS_TOP) : gsSel.idle;
    nConductance.mod  = pwrDown ? (gsSel.mod | GS_TOP) : gsSel.mod;
  end

  // modulation timing outputs
  always_comb
  begin
    millerPulseClocks = 9'h000;
    subLowClocks      = 5'h00;
    subHighClocks     = 5'h00;
    if (isInitiator)
      millerPulseClocks = {1'b0, pulse_width_value_r} + 9'h001;
    else if (isPassiveTarget106)
    begin
      subLowClocks  = {2'b00, pulse_width_value_r[2:0]} + 5'h01;
      subHighClocks = SUB_PERIOD - subLowClocks;
    end
  end

  assign uartSpeed           = {speed_r[7:5], speed_r[3:0]};
  assign transmitPhaseOffset = txPhase_r[6:0];
  assign receiveClockSource  = txPhase_r[RXCLK_BIT];

  // assertions
  property p_speed_reset;
    @(posedge ref_clk) reset |=> speed_r == RST_SPEED;
  endproperty
  a_speed_reset: assert property (p_speed_reset) else $error("speed reset wrong");

  property p_page_addr;
    @(posedge ref_clk) disable iff (reset) page_r[7] |-> effRegAddr[5:4] == page_r[1:0];
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page bits not used");

  property p_latch_addr;
    @(posedge ref_clk) disable iff (reset) !page_r[7] |-> effRegAddr == hostAddrLatch;
  endproperty
  a_latch_addr: assert property (p_latch_addr) else $error("latch address not used");

  property p_page_rsvd;
    @(posedge ref_clk) disable iff (reset) page_r[6:2] == 5'h00;
  endproperty
  a_page_rsvd: assert property (p_page_rsvd) else $error("reserved page bits set");

  property p_pwrdn;
    @(posedge ref_clk) disable iff (reset) pwrDown |-> nConductance.idle[3] && nConductance.mod[3];
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power-down top bit missing");

  property p_loadmod;
    @(posedge ref_clk) disable iff (reset)
      (ctrl_r[CTRL_LOADMOD] && !pwrDown) |-> nConductance == gsnOff_r;
  endproperty
  a_loadmod: assert property (p_loadmod) else $error("load modulation uses wrong fields");

  property p_sub_period;
    @(posedge ref_clk) disable iff (reset)
      (!isInitiator && isPassiveTarget106) |-> (subLowClocks + subHighClocks == 5'h10) && subLowClocks <= 5'h08;
  endproperty
  a_sub_period: assert property (p_sub_period) else $error("subcarrier period wrong");

  property p_miller;
    @(posedge ref_clk) disable iff (reset) isInitiator |-> millerPulseClocks == {1'b0, pulse_width_value_r} + 9'h001;
  endproperty
  a_miller: assert property (p_miller) else $error("miller width wrong");

  // write events on the speed and page registers
  sequence s_speed_wr;
    wrEn && regOff == OFF_SPEED;
  endsequence

  sequence s_page_wr;
    wrEn && regOff == OFF_PAGE;
  endsequence

  // a speed write keeps both factors, bit 4 reads zero
  property p_speed_wr;
    @(posedge ref_clk) disable iff (reset) s_speed_wr |=> speed_r == ($past(wrByte) & 8'hef);
  endproperty
  a_speed_wr: assert property (p_speed_wr) else $error("speed write lost");

  // a page write drops the reserved bits
  property p_page_wr;
    @(posedge ref_clk) disable iff (reset) s_page_wr |=> page_r == ($past(wrByte) & PAGE_MASK);
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write wrong");

  // plain bit order keeps the checksum bytes as they come
  property p_crc_plain;
    @(posedge ref_clk) disable iff (reset) !high_bit_first_order |-> crcHi == checksumValue[15:8] && crcLo == checksumValue[7:0];
  endproperty
  a_crc_plain: assert property (p_crc_plain) else $error("checksum bytes wrong");

  // high-bit-first mode swaps the end bits of each byte, bytes in place
  property p_crc_rev;
    @(posedge ref_clk) disable iff (reset)
      high_bit_first_order |-> crcHi[7] == checksumValue[8] && crcHi[0] == checksumValue[15] &&
                   crcLo[7] == checksumValue[0] && crcLo[0] == checksumValue[7];
  endproperty
  a_crc_rev: assert property (p_crc_rev) else $error("checksum bit order wrong");

  // with paging on and pins selected the pins give the low address bits
  property p_pins_addr;
    @(posedge ref_clk) disable iff (reset) (page_r[7] && hostUsesPins) |-> effRegAddr[3:0] == hostAddrPins;
  endproperty
  a_pins_addr: assert property (p_pins_addr) else $error("pin address not used");

  // driver on without load modulation uses the driver-on fields
  property p_drv_on;
    @(posedge ref_clk) disable iff (reset)
      (ctrl_r[CTRL_DRVON] && !ctrl_r[CTRL_LOADMOD] && !pwrDown) |-> nConductance == gsnOn_r;
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("driver-on fields not used");

  // driver off uses the driver-off fields
  property p_drv_off;
    @(posedge ref_clk) disable iff (reset) (!ctrl_r[CTRL_DRVON] && !pwrDown) |-> nConductance == gsnOff_r;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver-off fields not used");

  // no miller pulse unless initiator
  property p_miller_idle;
    @(posedge ref_clk) disable iff (reset) !isInitiator |-> millerPulseClocks == 9'h000;
  endproperty
  a_miller_idle: assert property (p_miller_idle) else $error("miller width outside initiator");

  // subcarrier low phase follows the width modulo eight
  property p_sub_low;
    @(posedge ref_clk) disable iff (reset)
      (!isInitiator && isPassiveTarget106) |-> subLowClocks == 5'(pulse_width_value_r % 8) + 5'h01;
  endproperty
  a_sub_low: assert property (p_sub_low) else $error("subcarrier low phase wrong");

  sequence s_phase_wr;
    wrEn && regOff == OFF_TXPHASE;
  endsequence
  property p_phase;
    @(posedge ref_clk) disable iff (reset)
      s_phase_wr |=> transmitPhaseOffset == $past(wrByte[6:0]) && receiveClockSource == $past(wrByte[7]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase write lost");
endmodule : nfcr_config_regs

// file: tb/nfcr_host_model.sv
// host side apb master model for the configuration registers
`timescale 1ns/1ps
module nfcr_host_model (
  input  wire logic        ref_clk,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [9:0]       paddr = 10'h000,
  output logic [31:0]      pwdata = 32'h0,
  output logic [3:0]       pstrb = 4'h0,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // one apb transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : nfcr_host_model

// file: tb/test_nfcr_config_regs.sv
// self-checking bench for the configuration page registers
`timescale 1ns/1ps
module test_nfcr_config_regs;
  import nfcr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [5:0]  hostAddrLatch = 6'h05;
  logic [5:0]  effRegAddr;
  logic [3:0]  hostAddrPins = 4'ha;
  logic        hostUsesPins = 1'b0;
  logic        checksumReady = 1'b1;
  logic        isInitiator = 1'b0;
  logic        isPassiveTarget106 = 1'b0;
  logic [15:0] checksumValue = 16'h12c5;
  nfcr_speed_t uartSpeed;
  nfcr_gsn_t   nConductance;
  logic [8:0]  millerPulseClocks;
  logic [4:0]  subLowClocks, subHighClocks;
  logic [6:0]  transmitPhaseOffset;
  logic        receiveClockSource;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  nfcr_config_regs #(.ADDR_W(10)) nfcr_config_regs_i (.ref_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .hostAddrLatch, .hostAddrPins, .hostUsesPins,
    .effRegAddr, .checksumValue, .checksumReady, .uartSpeed, .nConductance, .isInitiator,
    .isPassiveTarget106, .millerPulseClocks, .subLowClocks, .subHighClocks, .transmitPhaseOffset,
    .receiveClockSource);
  nfcr_host_model nfcr_host_model_i (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr);

  // clock and hang guard
  initial
    forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    nfcr_host_model_i.xfer(1'b1, {a, 2'b00}, d, q, e);
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    nfcr_host_model_i.xfer(1'b0, {a, 2'b00}, 32'h0, q, e);
    chk($sformatf("slverr %h", a), {31'h0, experr}, {31'h0, e});
    if (!experr)
      chk($sformatf("reg %h", a), exp, q);
  endtask : rd

  // mode and address-source inputs, changed on the rising edge
  task automatic mode(input logic ini, input logic pt, input logic pins);
    @(posedge ref_clk);
    isInitiator <= ini;
    isPassiveTarget106 <= pt;
    hostUsesPins <= pins;
    @(negedge ref_clk);
  endtask : mode

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFF_SPEED, 32'heb, 1'b0);
    rd(OFF_GSNOFF, 32'h88, 1'b0);
    rd(OFF_PULSE_WIDTH_VALUE, 32'h26, 1'b0);
    rd(OFF_TXPHASE, 32'h87, 1'b0);
    wr(OFF_SPEED, 32'hff);
    rd(OFF_SPEED, 32'hef, 1'b0);
    chk("speed", 32'h7f, {25'h0, uartSpeed});
    rd(8'h30, 32'h0, 1'b1);
    rd(OFF_STATUS, 32'h1, 1'b0);
    rd(OFF_CRC_HI, 32'h12, 1'b0);
    wr(OFF_CRC_LO, 32'h00);
    rd(OFF_CRC_LO, 32'hc5, 1'b0);
    wr(OFF_CTRL, 32'h02);
    rd(OFF_CRC_HI, 32'h48, 1'b0);
    rd(OFF_CRC_LO, 32'ha3, 1'b0);
    rd(OFF_PAGE, 32'h00, 1'b0);
    wr(OFF_PAGE, 32'hff);
    rd(OFF_PAGE, 32'h83, 1'b0);
    chk("addr latch", 32'h35, {26'h0, effRegAddr});
    mode(1'b0, 1'b0, 1'b1);
    chk("addr pins", 32'h3a, {26'h0, effRegAddr});
    wr(OFF_PAGE, 32'h03);
    chk("addr whole", 32'h05, {26'h0, effRegAddr});
    wr(OFF_GSNOFF, 32'h5a);
    wr(OFF_GSNON, 32'h43);
    chk("gsn off", 32'h5a, {24'h0, nConductance});
    wr(OFF_CTRL, 32'h04);
    chk("gsn on", 32'h43, {24'h0, nConductance});
    wr(OFF_CTRL, 32'h0c);
    chk("gsn load", 32'h5a, {24'h0, nConductance});
    wr(OFF_CTRL, 32'h05);
    chk("gsn pwrdn", 32'hcb, {24'h0, nConductance});
    wr(OFF_PULSE_WIDTH_VALUE, 32'hff);
    mode(1'b1, 1'b1, 1'b0);
    chk("miller", 32'h100, {23'h0, millerPulseClocks});
    mode(1'b0, 1'b1, 1'b0);
    chk("sub low", 32'h8, {27'h0, subLowClocks});
    wr(OFF_PULSE_WIDTH_VALUE, 32'h0d);
    chk("sub low", 32'h6, {27'h0, subLowClocks});
    chk("sub high", 32'ha, {27'h0, subHighClocks});
    wr(OFF_TXPHASE, 32'h7f);
    chk("phase", 32'h7f, {25'h0, transmitPhaseOffset});
    chk("rx clk", 32'h0, {31'h0, receiveClockSource});
    wr(OFF_TXPHASE, 32'h80);
    chk("phase", 32'h00, {25'h0, transmitPhaseOffset});
    chk("rx clk", 32'h1, {31'h0, receiveClockSource});
    print_verdict();
  end
endmodule : test_nfcr_config_regs
